// ---- hw/timer8_params.svh ----
/*
 * register offsets, field positions, reset values and prescaler width
 * of the 8-bit timer. assumes inclusion by bare name, definitions only.
 */
`ifndef TIMER8_PARAMS_SVH
`define TIMER8_PARAMS_SVH
// register byte offsets on the APB window
`define OFS_CTRL_A   8'h00
`define OFS_CTRL_B   8'h04
`define OFS_COUNT    8'h08
`define OFS_CMP_A    8'h0C
`define OFS_CMP_B    8'h10
`define OFS_MASK     8'h14
`define OFS_FLAG     8'h18
`define OFS_ASYNC    8'h1C
`define OFS_DIR      8'h20
// field positions
`define CA_WGM_LO    0
`define CA_COM_B     4
`define CA_COM_A     6
`define CB_CS        0
`define CB_WGM2      3
`define CB_FOC_B     6
`define CB_FOC_A     7
`define FLG_OVF      0
`define FLG_A        1
`define FLG_B        2
`define AS_SEL       5
`define DIR_A        0
`define DIR_B        1
// values
`define CNT_MAX      8'hFF
`define CNT_BOTTOM   8'h00
`define RST_BYTE     8'h00
`define RST_FLAGS    3'h0
`define RST_DIR      2'h0
// prescaler width
`define PS_W         10
`endif

// ---- hw/timer8_pkg.sv ----
/*
 * types of the 8-bit timer: counting kinds and their decode.
 * assumes timer8_params.svh on the include path.
 */
package timer8_pkg;
    // counting behaviour, one-hot
    typedef enum logic [3:0] {
        K_NORMAL   = 4'b0001,
        K_CTC      = 4'b0010,
        K_PWM_FF   = 4'b0100,
        K_PWM_OCRA = 4'b1000
    } count_kind_t;

    // waveform mode field to counting kind
    function automatic count_kind_t decode_kind(input logic [2:0] wgm);
        case (wgm)
            3'h0: decode_kind = K_NORMAL;
            3'h2: decode_kind = K_CTC;
            3'h1, 3'h3: decode_kind = K_PWM_FF;
            3'h5, 3'h7: decode_kind = K_PWM_OCRA;
            default: decode_kind = K_NORMAL;
        endcase
    endfunction : decode_kind
endpackage : timer8_pkg

// ---- hw/tick_prescaler.sv ----
/*
 * free-running prescaler turning source pulses into timer ticks.
 * assumes src_en is a one-cycle pulse in the clk domain.
 */
`include "timer8_params.svh"
module tick_prescaler import timer8_pkg::*; #(
    parameter int W = `PS_W
) (
    input  wire logic       clk,    // system clock
    input  wire logic       rst_n,  // async reset, low
    input  wire logic       src_en, // source pulse
    input  wire logic [2:0] sel,    // clock select field
    output logic            tick    // timer tick pulse
);
    logic [W-1:0] cnt_q;

    // tap is complete when low bits are all ones
    function automatic logic tap_full(input logic [2:0] s, input logic [W-1:0] c);
        case (s)
            3'h1: tap_full = 1'b1;
            3'h2: tap_full = &c[2:0];
            3'h3: tap_full = &c[4:0];
            3'h4: tap_full = &c[5:0];
            3'h5: tap_full = &c[6:0];
            3'h6: tap_full = &c[7:0];
            3'h7: tap_full = &c[9:0];
            default: tap_full = 1'b0;
        endcase
    endfunction : tap_full

    // divider counts source pulses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (src_en) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // no tick for select zero
    assign tick = src_en & tap_full(sel, cnt_q);

    AST_DIV8_SPACING: assert property (@(posedge clk) disable iff (!rst_n)
        tick && sel == 3'h2 && $stable(sel) |=> !tick [*7])
        else $error("divide-by-8 tick came early");
endmodule : tick_prescaler

// ---- hw/compare_channel.sv ----
/*
 * one compare channel: buffered compare value, match and waveform.
 * assumes tick, bottom and force are one-cycle pulses on clk.
 */
module compare_channel (
    input  wire logic       clk,     // system clock
    input  wire logic       rst_n,   // async reset, low
    input  wire logic       tick,    // timer tick
    input  wire logic [7:0] cnt,     // counter value
    input  wire logic [7:0] buf_val, // value written by software
    input  wire logic       pwm,     // pwm counting active
    input  wire logic       bottom,  // tick of top to bottom
    input  wire logic [1:0] com,     // compare output mode
    input  wire logic       force_s, // force compare strobe
    input  wire logic       blocked, // match suppressed
    output logic [7:0]      ocr,     // compare value in use
    output logic            hit,     // match pulse
    output logic            wave_q   // waveform output
);
    logic [7:0] active_q;

    // reload at bottom in pwm, direct otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 8'h00;
        end else if (!pwm || bottom) begin
            active_q <= buf_val;
        end
    end

    assign ocr = pwm ? active_q : buf_val;
    assign hit = tick & (cnt == ocr) & ~blocked;

    // waveform generator, bottom wins over match for constant level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wave_q <= 1'b0;
        end else if (pwm) begin
            if (bottom && com[1]) begin
                wave_q <= ~com[0];
            end else if (hit) begin
                case (com)
                    2'h1: wave_q <= ~wave_q;
                    2'h2: wave_q <= 1'b0;
                    2'h3: wave_q <= 1'b1;
                    default: wave_q <= wave_q;
                endcase
            end
        end else if (hit || force_s) begin
            case (com)
                2'h1: wave_q <= ~wave_q;
                2'h2: wave_q <= 1'b0;
                2'h3: wave_q <= 1'b1;
                default: wave_q <= wave_q;
            endcase
        end
    end

    AST_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n)
        hit && !pwm && com == 2'h1 |=> wave_q != $past(wave_q))
        else $error("toggle on match missing");
endmodule : compare_channel

// ---- hw/timer8_ctc_fast_pwm.sv ----
/*
 * 8-bit timer with two compare channels, normal, ctc and fast pwm
 * counting, flags with masks, APB register slave.
 * assumes one 20 MHz clock and the crystal on an unsynchronised pin.
 */
// Chosen here: register access over APB and the register addresses.
//Contract
//- counter and both compare values are 8 bits wide.
//- each request is a flag gated by its own mask bit.
//- clock select zero gives no tick; counter holds.
//- tick source is the system clock unless async select is one.
//- software reads and writes the counter; write beats count and clear.
//- both compare values are compared with the counter always.
//- 3-bit waveform mode: two low bits in control A, top in B.
//- compare output modes never change the counting sequence.
//- non-pwm: output mode selects set, clear or toggle on match.
//- mode zero counts up only and wraps FF to 00.
//- mode zero sets overflow when counter becomes zero; set only.
//- mode two clears the counter on match with compare A.
//- mode two compare A unbuffered; missed match runs to FF.
//- mode two with output mode 1 toggles output A per match.
//- waveform reaches its pin only while direction is output.
//- mode two sets overflow when passing FF to 00.
//- fast pwm sets overflow each time counter reaches top.
//- fast pwm top is FF for mode 3, compare A for mode 7.
//- fast pwm output mode 2 non-inverted, 3 inverted.
//- fast pwm: change at match, opposite change at top to zero.
//- compare zero gives spike per 256 ticks; max gives constant.
//- fast pwm output mode 1 toggles per match, buffering kept.
//- prescale divisors 1, 8, 32, 64, 128, 256 and 1024.
//- compare values buffered in pwm, direct in normal and ctc.
//- match sets flag at the tick; write one or service clears.
//- counter write suppresses matches of the next tick.
//- force strobe in non-pwm acts as match, no flag or clear.
`include "timer8_params.svh"
module timer8_ctc_fast_pwm import timer8_pkg::*; (
    input  wire logic        clk,        // system clock
    input  wire logic        rst_n,      // async reset, low
    input  wire logic        psel,       // apb select
    input  wire logic        penable,    // apb enable
    input  wire logic        pwrite,     // apb direction
    input  wire logic [7:0]  paddr,      // apb byte address
    input  wire logic [31:0] pwdata,     // apb write data
    output logic [31:0]      prdata,     // apb read data
    output logic             pready,     // apb ready
    output logic             pslverr,    // apb error
    input  wire logic        crystal_in, // crystal oscillator pin
    input  wire logic        ack_ovf,    // overflow serviced
    input  wire logic        ack_cmp_a,  // compare a serviced
    input  wire logic        ack_cmp_b,  // compare b serviced
    output logic             irq_ovf,    // overflow request
    output logic             irq_cmp_a,  // compare a request
    output logic             irq_cmp_b,  // compare b request
    output logic             wave_a_o,   // pin a data
    output logic             wave_a_oe,  // pin a enable
    output logic             wave_b_o,   // pin b data
    output logic             wave_b_oe   // pin b enable
);
    logic [7:0]  ctrl_a_q;
    logic [7:0]  ctrl_b_q;
    logic [7:0]  cnt_q;
    logic [7:0]  cmp_a_buf_q;
    logic [7:0]  cmp_b_buf_q;
    logic [2:0]  mask_q;
    logic [2:0]  flag_q;
    logic [2:0]  flag_set;
    logic [2:0]  flag_clr;
    logic        async_q;
    logic [1:0]  dir_q;
    logic        block_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        x1_q;
    logic        x2_q;
    logic        x3_q;
    logic        xlvl_q;
    logic        xrise;
    logic        src_en;
    logic        tick;
    logic [2:0]  wgm;
    count_kind_t kind;
    logic        pwm;
    logic [7:0]  top;
    logic        at_top;
    logic        ovf_evt;
    logic        bottom;
    logic [7:0]  ocr_a;
    logic [7:0]  ocr_b;
    logic        hit_a;
    logic        hit_b;
    logic        wave_a_q;
    logic        wave_b_q;
    logic        setup;
    logic        wr;
    logic        wr_cnt;
    logic        wr_b;
    logic        force_a;
    logic        force_b;

    // address decode
    function automatic logic addr_ok(input logic [7:0] a);
        case (a)
            `OFS_CTRL_A, `OFS_CTRL_B, `OFS_COUNT, `OFS_CMP_A, `OFS_CMP_B,
            `OFS_MASK, `OFS_FLAG, `OFS_ASYNC, `OFS_DIR: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    endfunction : addr_ok

    // apb strobes, zero wait states
    assign setup  = psel & ~penable;
    assign wr     = psel & penable & pwrite & addr_ok(paddr);
    assign wr_cnt = wr & (paddr == `OFS_COUNT);
    assign wr_b   = wr & (paddr == `OFS_CTRL_B);
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    // read data captured in the setup cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pslverr_q <= ~addr_ok(paddr);
            case (paddr)
                `OFS_CTRL_A: prdata_q <= {24'h0, ctrl_a_q};
                `OFS_CTRL_B: prdata_q <= {24'h0, ctrl_b_q};
                `OFS_COUNT:  prdata_q <= {24'h0, cnt_q};
                `OFS_CMP_A:  prdata_q <= {24'h0, cmp_a_buf_q};
                `OFS_CMP_B:  prdata_q <= {24'h0, cmp_b_buf_q};
                `OFS_MASK:   prdata_q <= {29'h0, mask_q};
                `OFS_FLAG:   prdata_q <= {29'h0, flag_q};
                `OFS_ASYNC:  prdata_q <= {26'h0, async_q, 5'h0};
                `OFS_DIR:    prdata_q <= {30'h0, dir_q};
                default:     prdata_q <= '0;
            endcase
        end
    end

    // configuration registers; force strobes are not stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_a_q    <= `RST_BYTE;
            ctrl_b_q    <= `RST_BYTE;
            cmp_a_buf_q <= `RST_BYTE;
            cmp_b_buf_q <= `RST_BYTE;
            mask_q      <= `RST_FLAGS;
            async_q     <= 1'b0;
            dir_q       <= `RST_DIR;
        end else if (wr) begin
            case (paddr)
                `OFS_CTRL_A: ctrl_a_q <= pwdata[7:0];
                `OFS_CTRL_B: ctrl_b_q <= {2'h0, pwdata[5:0]};
                `OFS_CMP_A:  cmp_a_buf_q <= pwdata[7:0];
                `OFS_CMP_B:  cmp_b_buf_q <= pwdata[7:0];
                `OFS_MASK:   mask_q <= pwdata[2:0];
                `OFS_ASYNC:  async_q <= pwdata[`AS_SEL];
                `OFS_DIR:    dir_q <= pwdata[1:0];
                default:     async_q <= async_q;
            endcase
        end
    end

    // crystal pin: three flops, change accepted once two agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            x1_q   <= 1'b0;
            x2_q   <= 1'b0;
            x3_q   <= 1'b0;
            xlvl_q <= 1'b0;
        end else begin
            x1_q <= crystal_in;
            x2_q <= x1_q;
            x3_q <= x2_q;
            if (x2_q == x3_q) begin
                xlvl_q <= x3_q;
            end
        end
    end

    // tick source select
    assign xrise  = (x2_q == x3_q) & x3_q & ~xlvl_q;
    assign src_en = async_q ? xrise : 1'b1;

    tick_prescaler #(
        .W (`PS_W)
    ) u_presc (
        .clk    (clk),
        .rst_n  (rst_n),
        .src_en (src_en),
        .sel    (ctrl_b_q[`CB_CS +: 3]),
        .tick   (tick)
    );

    // mode decode; output mode bits take no part
    assign wgm  = {ctrl_b_q[`CB_WGM2], ctrl_a_q[`CA_WGM_LO +: 2]};
    assign kind = decode_kind(wgm);
    assign pwm  = (kind == K_PWM_FF) || (kind == K_PWM_OCRA);
    assign top  = (kind == K_CTC || kind == K_PWM_OCRA) ? ocr_a : `CNT_MAX;
    assign at_top = (cnt_q == top);
    assign bottom = tick & pwm & at_top;

    // overflow: wrap of FF in normal and ctc, top in pwm
    assign ovf_evt = tick & (pwm ? at_top : (cnt_q == `CNT_MAX));

    // counter; software write first, then clear, then count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= `CNT_BOTTOM;
        end else if (wr_cnt) begin
            cnt_q <= pwdata[7:0];
        end else if (tick) begin
            if (at_top && kind != K_NORMAL) begin
                cnt_q <= `CNT_BOTTOM;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    // match block from a counter write until the next tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            block_q <= 1'b0;
        end else if (wr_cnt) begin
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    // force strobes only outside pwm
    assign force_a = wr_b & pwdata[`CB_FOC_A] & ~pwm;
    assign force_b = wr_b & pwdata[`CB_FOC_B] & ~pwm;

    compare_channel u_cha (
        .clk     (clk),
        .rst_n   (rst_n),
        .tick    (tick),
        .cnt     (cnt_q),
        .buf_val (cmp_a_buf_q),
        .pwm     (pwm),
        .bottom  (bottom),
        .com     (ctrl_a_q[`CA_COM_A +: 2]),
        .force_s (force_a),
        .blocked (block_q),
        .ocr     (ocr_a),
        .hit     (hit_a),
        .wave_q  (wave_a_q)
    );

    compare_channel u_chb (
        .clk     (clk),
        .rst_n   (rst_n),
        .tick    (tick),
        .cnt     (cnt_q),
        .buf_val (cmp_b_buf_q),
        .pwm     (pwm),
        .bottom  (bottom),
        .com     (ctrl_a_q[`CA_COM_B +: 2]),
        .force_s (force_b),
        .blocked (block_q),
        .ocr     (ocr_b),
        .hit     (hit_b),
        .wave_q  (wave_b_q)
    );

    // flags: set by events, cleared by write one or service
    assign flag_set = {hit_b, hit_a, ovf_evt};
    assign flag_clr = ({3{wr && paddr == `OFS_FLAG}} & pwdata[2:0])
                    | {ack_cmp_b, ack_cmp_a, ack_ovf};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= `RST_FLAGS;
        end else begin
            flag_q <= (flag_q & ~flag_clr) | flag_set;
        end
    end

    // requests gated by mask
    assign irq_ovf   = flag_q[`FLG_OVF] & mask_q[`FLG_OVF];
    assign irq_cmp_a = flag_q[`FLG_A] & mask_q[`FLG_A];
    assign irq_cmp_b = flag_q[`FLG_B] & mask_q[`FLG_B];

    // pins driven only when direction is output
    assign wave_a_o  = wave_a_q;
    assign wave_b_o  = wave_b_q;
    assign wave_a_oe = dir_q[`DIR_A];
    assign wave_b_oe = dir_q[`DIR_B];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_STOP_HOLD: assert property (
        ctrl_b_q[`CB_CS +: 3] == 3'h0 && !wr_cnt |=> cnt_q == $past(cnt_q))
        else $error("counter moved while stopped");
    AST_WR_PRIO: assert property (
        wr_cnt |=> cnt_q == $past(pwdata[7:0]))
        else $error("counter write lost");
    AST_NORMAL_WRAP: assert property (
        tick && kind == K_NORMAL && cnt_q == `CNT_MAX && !wr_cnt |=> cnt_q == 8'h00)
        else $error("normal mode did not wrap");
    AST_OVF_ZERO: assert property (
        tick && kind == K_NORMAL && cnt_q == `CNT_MAX && !wr_cnt
        |=> flag_q[`FLG_OVF] && cnt_q == 8'h00)
        else $error("overflow not set with zero");
    AST_CTC_CLEAR: assert property (
        tick && kind == K_CTC && cnt_q == cmp_a_buf_q && !wr_cnt |=> cnt_q == 8'h00)
        else $error("ctc clear missing");
    AST_PWM_TOP: assert property (
        bottom && !wr_cnt |=> cnt_q == 8'h00 && flag_q[`FLG_OVF])
        else $error("pwm top handling wrong");
    AST_BLOCK: assert property (
        block_q && tick && !pwm && !force_a && !flag_q[`FLG_B]
        |=> wave_a_q == $past(wave_a_q) && !flag_q[`FLG_B])
        else $error("match not blocked after write");
    AST_CMP_FLAG: assert property (
        hit_b |=> flag_q[`FLG_B])
        else $error("compare flag not set");
    AST_IRQ_GATE: assert property (
        !mask_q[`FLG_A] |-> !irq_cmp_a)
        else $error("masked request escaped");
    AST_PIN_DIR: assert property (
        wr && paddr == `OFS_DIR |=> wave_b_oe == $past(pwdata[`DIR_B]))
        else $error("pin enable does not follow direction");

    // waveform, buffering and force checks
    AST_PWM_SET_BOTTOM: assert property (
        bottom && ctrl_a_q[`CA_COM_A +: 2] == 2'h2 |=> wave_a_q)
        else $error("non-inverted output not set at bottom");
    AST_PWM_CLR_MATCH: assert property (
        hit_a && pwm && !bottom && ctrl_a_q[`CA_COM_A +: 2] == 2'h2 |=> !wave_a_q)
        else $error("non-inverted output not cleared at match");
    AST_BUF_HOLD: assert property (
        pwm && !bottom |=> !pwm || ocr_a == $past(ocr_a))
        else $error("compare value changed away from bottom");
    AST_FORCE_NOFLAG: assert property (
        force_b && !hit_b && !flag_q[`FLG_B] |=> !flag_q[`FLG_B])
        else $error("force strobe set the compare flag");
endmodule : timer8_ctc_fast_pwm

// ---- test/test_timer8_ctc_fast_pwm.sv ----
/*
 * self-checking bench for the 8-bit timer: apb register access, counting
 * modes, flags, masks and waveform checks.
 * assumes timer8_params.svh on the include path and the package compiled.
 */
`include "timer8_params.svh"
module test_timer8_ctc_fast_pwm;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err, pick_b;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        crystal_in, ack_ovf, ack_cmp_a, ack_cmp_b, irq_ovf, irq_cmp_a, irq_cmp_b;
    logic        wave_a_o, wave_a_oe, wave_b_o, wave_b_oe, last;
    int          num_errors, n_tests, cycles, hi, tg;
    int          divs[7] = '{1, 8, 32, 64, 128, 256, 1024};
    wire logic   wv = pick_b ? wave_b_o : wave_a_o;

    timer8_ctc_fast_pwm DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .crystal_in(crystal_in), .ack_ovf(ack_ovf),
        .ack_cmp_a(ack_cmp_a), .ack_cmp_b(ack_cmp_b), .irq_ovf(irq_ovf),
        .irq_cmp_a(irq_cmp_a), .irq_cmp_b(irq_cmp_b), .wave_a_o(wave_a_o),
        .wave_a_oe(wave_a_oe), .wave_b_o(wave_b_o), .wave_b_oe(wave_b_oe));

    // clock of 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // verdict and end of run
    task automatic results();
        if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles > 40000) begin
            num_errors++;
            results();
        end
    end

    // one apb transfer, then one idle edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            $display("Error %s expected %h seen %h", nm, ex, got);
            num_errors++;
        end
    endtask : chk

    task automatic rng(input string nm, input int lo, input int up, input logic [31:0] got);
        n_tests++;
        if ($isunknown(got) || got < lo || got > up) begin
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, up, got);
            num_errors++;
        end
    endtask : rng

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk(nm, ex, rd);
    endtask : rc

    // high samples and edges of the picked waveform over n cycles
    task automatic meas(input int n);
        hi = 0;
        tg = 0;
        @(negedge clk);
        last = wv;
        repeat (n) begin
            @(negedge clk);
            if (wv === 1'b1) hi++;
            if (wv !== last) tg++;
            last = wv;
        end
        @(posedge clk);
    endtask : meas

    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, crystal_in} = '0;
        {ack_ovf, ack_cmp_a, ack_cmp_b, pick_b} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i <= 8; i++) rc("reset value", 8'(4 * i), 32'h0);
        chk("pin enables", 32'h0, {wave_a_oe, wave_b_oe});
        rc("unmapped data", 8'h24, 32'h0);
        chk("unmapped error", 32'h1, err);
        wr(`OFS_COUNT, 32'h1AB);
        repeat (20) @(posedge clk);
        rc("stopped counter", `OFS_COUNT, 32'hAB);
        // every prescale tap counts about eight ticks
        for (int i = 0; i < 7; i++) begin
            wr(`OFS_COUNT, 32'h0);
            wr(`OFS_CTRL_B, 32'(i + 1));
            repeat (8 * divs[i] - 2) @(posedge clk);
            wr(`OFS_CTRL_B, 32'h0);
            apb(1'b0, `OFS_COUNT, 32'h0);
            rng("prescale count", 7, 10, rd[7:0]);
        end
        // normal mode wrap, flags and masks
        wr(`OFS_FLAG, 32'h7);
        wr(`OFS_CMP_B, 32'h01);
        wr(`OFS_MASK, 32'h1);
        wr(`OFS_COUNT, 32'hFC);
        wr(`OFS_CTRL_B, 32'h1);
        for (int k = 0; k < 50 && irq_ovf !== 1'b1; k++) @(posedge clk);
        wr(`OFS_CTRL_B, 32'h0);
        chk("overflow request", 32'h1, irq_ovf);
        chk("masked request", 32'h0, irq_cmp_a);
        apb(1'b0, `OFS_COUNT, 32'h0);
        rng("wrapped count", 1, 8, rd[7:0]);
        rc("flags after wrap", `OFS_FLAG, 32'h7);
        wr(`OFS_FLAG, 32'h1);
        rc("flag write one", `OFS_FLAG, 32'h6);
        wr(`OFS_MASK, 32'h6);
        chk("request a", 32'h1, irq_cmp_a);
        ack_cmp_a <= 1'b1;
        @(posedge clk);
        ack_cmp_a <= 1'b0;
        repeat (2) @(posedge clk);
        chk("serviced a", 32'h0, irq_cmp_a);
        chk("request b", 32'h1, irq_cmp_b);
        // counter write blocks the match of the next tick
        wr(`OFS_FLAG, 32'h7);
        wr(`OFS_CMP_B, 32'h10);
        wr(`OFS_COUNT, 32'h10);
        wr(`OFS_CTRL_B, 32'h1);
        wr(`OFS_CTRL_B, 32'h0);
        rc("blocked match", `OFS_FLAG, 32'h0);
        // force strobe toggles b without flag
        wr(`OFS_CTRL_A, 32'h10);
        wr(`OFS_DIR, 32'h2);
        last = wave_b_o;
        wr(`OFS_CTRL_B, 32'h40);
        @(negedge clk);
        chk("forced wave", {31'h0, ~last}, wave_b_o);
        chk("pin enables", 32'h1, {wave_a_oe, wave_b_oe});
        @(posedge clk);
        rc("forced flag", `OFS_FLAG, 32'h0);
        // ctc toggling on channel a
        wr(`OFS_COUNT, 32'h0);
        wr(`OFS_CMP_A, 32'h3);
        wr(`OFS_DIR, 32'h1);
        wr(`OFS_CTRL_A, 32'h42);
        wr(`OFS_CTRL_B, 32'h1);
        meas(80);
        rng("ctc toggles", 19, 21, tg);
        apb(1'b0, `OFS_COUNT, 32'h0);
        rng("ctc count", 0, 3, rd[7:0]);
        // missed top runs on past it, then overflows
        wr(`OFS_CTRL_B, 32'h0);
        wr(`OFS_FLAG, 32'h7);
        wr(`OFS_COUNT, 32'h10);
        wr(`OFS_CTRL_B, 32'h1);
        repeat (20) @(posedge clk);
        apb(1'b0, `OFS_COUNT, 32'h0);
        rng("missed top", 17, 64, rd[7:0]);
        repeat (300) @(posedge clk);
        apb(1'b0, `OFS_FLAG, 32'h0);
        chk("ctc overflow", 32'h1, rd[0]);
        // fast pwm top FF, both polarities and constant level
        wr(`OFS_CMP_A, 32'h3F);
        wr(`OFS_CTRL_A, 32'h83);
        wr(`OFS_FLAG, 32'h7);
        repeat (300) @(posedge clk);
        meas(512);
        rng("pwm high", 126, 130, hi);
        rng("pwm edges", 3, 5, tg);
        apb(1'b0, `OFS_FLAG, 32'h0);
        chk("pwm overflow", 32'h1, rd[0]);
        wr(`OFS_CTRL_A, 32'hC3);
        repeat (300) @(posedge clk);
        meas(512);
        rng("inverted high", 382, 386, hi);
        wr(`OFS_CMP_A, 32'hFF);
        wr(`OFS_CTRL_A, 32'h83);
        repeat (300) @(posedge clk);
        meas(512);
        rng("max compare", 512, 512, hi);
        // fast pwm with compare a as top, waveform on b
        wr(`OFS_CMP_A, 32'h3F);
        wr(`OFS_CMP_B, 32'h0F);
        wr(`OFS_CTRL_A, 32'h23);
        wr(`OFS_CTRL_B, 32'h09);
        wr(`OFS_DIR, 32'h3);
        repeat (300) @(posedge clk);
        pick_b = 1'b1;
        meas(512);
        rng("top a high", 126, 130, hi);
        apb(1'b0, `OFS_COUNT, 32'h0);
        rng("top a count", 0, 63, rd[7:0]);
        // crystal edges as tick source
        wr(`OFS_CTRL_B, 32'h0);
        wr(`OFS_CTRL_A, 32'h01);
        wr(`OFS_COUNT, 32'h0);
        wr(`OFS_ASYNC, 32'h20);
        wr(`OFS_CTRL_B, 32'h09);
        repeat (10) begin
            repeat (4) @(posedge clk);
            crystal_in <= 1'b1;
            repeat (4) @(posedge clk);
            crystal_in <= 1'b0;
        end
        repeat (10) @(posedge clk);
        wr(`OFS_CTRL_B, 32'h0);
        rc("crystal count", `OFS_COUNT, 32'h0A);
        results();
    end
endmodule : test_timer8_ctc_fast_pwm
